/* File: rtl/sef_params.svh */
`ifndef SEF_PARAMS_SVH
`define SEF_PARAMS_SVH

// register map, byte addresses on the apb
`define SEF_ADDR_W 12
`define SEF_OFS_ENABLE 12'h000
`define SEF_OFS_FLAGS 12'h004
`define SEF_OFS_MODE 12'h008
`define SEF_OFS_STATUS 12'h00C

// flag and enable bit positions (shared layout)
`define SEF_B_RX_ERROR 7
`define SEF_B_EOP 6
`define SEF_B_SYNC 5
`define SEF_B_TX_EMPTY 4
`define SEF_B_TX_UNDERRUN 3
`define SEF_B_LINK_PULSE 2
`define SEF_B_RX_FULL 1
`define SEF_B_CARRIER 0

// status register bit positions
`define SEF_B_ST_TX_LOADED 0
`define SEF_B_ST_LINK_PIN 1
`define SEF_B_ST_FRAME_PIN 2
`define SEF_B_ST_RX_EN_PIN 3

// reset values
`define SEF_ENABLE_RST 8'h00
`define SEF_FLAGS_RST 8'h00
`define SEF_MODE_RST 3'h0
`define SEF_SYNC_RST 3'h0

// timing
`define SEF_CLK_PERIOD_NS 40
`define SEF_LP_MIN_NS 60
`define SEF_LP_MAX_NS 200
`define SEF_LP_CNT_W 4

// usb bit unstuffing: this many ones in a row is an error
`define SEF_ONES_LIMIT 7
`define SEF_ONES_W 3

`endif

/* File: rtl/sef_pkg.sv */
`include "sef_params.svh"

package sef_pkg;

  typedef enum logic [2:0] {
    SEF_MODE_OFF = 3'h0,
    SEF_MODE_10BT = 3'h1,
    SEF_MODE_USB = 3'h2,
    SEF_MODE_UART = 3'h3,
    SEF_MODE_SPI = 3'h5,
    SEF_MODE_GPSI = 3'h6
  } sef_mode_t;

  typedef enum logic [2:0] {
    SEF_LP_IDLE = 3'b001,
    SEF_LP_HIGH = 3'b010,
    SEF_LP_LONG = 3'b100
  } sef_lp_st_t;

  // event and level inputs from the serializer datapath, core clock domain
  typedef struct packed {
    logic manch_err;
    logic rx_bit_vld;
    logic rx_bit;
    logic rx_eop;
    logic sync_det;
    logic tx_load;
    logic tx_take;
    logic tx_shift_done;
    logic tx_busy;
    logic rx_buf_full;
    logic rx_busy;
    logic carrier;
  } sef_evt_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`SEF_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } sef_apb_req_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] filt;
  } sef_pinsync_t;

  typedef struct packed {
    logic [7:0] enable;
    logic [7:0] flags;
    sef_mode_t mode;
    sef_pinsync_t pins;
    sef_lp_st_t lp_st;
    logic [`SEF_LP_CNT_W-1:0] lp_cnt;
    logic [`SEF_ONES_W-1:0] ones;
    logic tx_loaded;
    logic rx_full_prev;
    logic tx_eop_req;
    logic irq;
    logic [31:0] prdata;
  } sef_state_t;

endpackage

/* File: rtl/sef_event_flags.sv */
// Functional notes
// RULE_01 - enable register mirrors flag layout, gates interrupts
// RULE_02 - flag bits seven down to zero fixed
// RULE_03 - 10BASE-T Manchester phase error sets receive error
// RULE_04 - USB seven ones in a row sets receive error
// RULE_05 - event flags stay set until software clears
// RULE_06 - 10BASE-T/USB line end of packet sets flag
// RULE_07 - GPSI receive enable falling sets end flag
// RULE_08 - SPI framing rising edge sets end flag
// RULE_09 - sync detected only in 10BASE-T and USB
// RULE_10 - transmit buffer becoming empty sets flag
// RULE_11 - shift done with empty buffer sets underrun
// RULE_12 - USB/10BASE-T underrun requests line end of packet
// RULE_13 - Ethernet link pulse 60 to 200 ns sets flag
// RULE_14 - USB: link bit shows transmitter idle live
// RULE_15 - receive buffer becoming full sets flag
// RULE_16 - carrier bit live; USB shows not receiving
// RULE_17 - 10BASE-T holds carrier bit at zero
// RULE_18 - three-bit protocol select steers flag meaning
// RULE_19 - irq while flag and enable; write zero clears
`timescale 1ns/1ns
`default_nettype none

`include "sef_params.svh"

module sef_event_flags #(
  parameter int LP_MIN_NS = `SEF_LP_MIN_NS,
  parameter int LP_MAX_NS = `SEF_LP_MAX_NS,
  parameter int CLK_PERIOD_NS = `SEF_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // apb slave
  input wire sef_pkg::sef_apb_req_t I_APB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // datapath events, same clock
  input wire sef_pkg::sef_evt_t I_EVT,
  // line pins, asynchronous
  input wire logic I_LINK_PULSE,
  input wire logic I_FRAME,
  input wire logic I_RECEIVE_ENABLE_INPUT,
  // to datapath and core
  output logic [2:0] O_PROTOCOL_SELECT,
  output logic O_TX_EOP_REQ,
  output logic O_IRQ
);
  import sef_pkg::*;

  // least time rounds up, longest time rounds down
  localparam int LP_MIN_CYC_RAW = (LP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LP_MIN_CYC = (LP_MIN_CYC_RAW < 1) ? 1 : LP_MIN_CYC_RAW;
  localparam int LP_MAX_CYC = LP_MAX_NS / CLK_PERIOD_NS;
  localparam int LP_CNT_MAX = (1 << `SEF_LP_CNT_W) - 1;
  localparam logic [`SEF_LP_CNT_W-1:0] LP_MIN_C = LP_MIN_CYC[`SEF_LP_CNT_W-1:0];
  localparam logic [`SEF_LP_CNT_W-1:0] LP_MAX_C = LP_MAX_CYC[`SEF_LP_CNT_W-1:0];
  localparam int ONES_LAST_I = `SEF_ONES_LIMIT - 1;
  localparam logic [`SEF_ONES_W-1:0] ONES_LAST = ONES_LAST_I[`SEF_ONES_W-1:0];

  // pin index inside the synchroniser vectors
  localparam int P_LINK = 0;
  localparam int P_FRAME = 1;
  localparam int P_RECEIVE_ENABLE_INPUT = 2;

  // refuse parameter sets that the counters cannot serve, before any simulation starts
  if (LP_MAX_CYC < LP_MIN_CYC || LP_MAX_CYC < 1 || LP_MAX_CYC >= LP_CNT_MAX) begin : g_lp_chk
    $error("link pulse window does not fit the pulse counter");
  end
  if (ONES_LAST_I < 1 || ONES_LAST_I >= (1 << `SEF_ONES_W)) begin : g_ones_chk
    $error("unstuffing limit does not fit the ones counter");
  end

  sef_state_t st_r;
  sef_state_t st_nxt;

  logic acc;
  logic setup;
  logic wr;
  logic hit_en;
  logic hit_fl;
  logic hit_md;
  logic hit_st;
  logic mapped;
  logic is_10bt;
  logic is_usb;
  logic [2:0] pin_prev;
  logic [7:0] ev;
  logic [7:0] clr;
  logic [7:0] sticky_msk;
  logic [7:0] live;
  logic lp_ok;
  logic underrun;

  assign acc = I_APB.psel & I_APB.penable;
  assign setup = I_APB.psel & ~I_APB.penable;
  assign wr = acc & I_APB.pwrite;
  assign hit_en = (I_APB.paddr == `SEF_OFS_ENABLE);
  assign hit_fl = (I_APB.paddr == `SEF_OFS_FLAGS);
  assign hit_md = (I_APB.paddr == `SEF_OFS_MODE);
  assign hit_st = (I_APB.paddr == `SEF_OFS_STATUS);
  assign mapped = hit_en | hit_fl | hit_md | hit_st;

  assign is_10bt = (st_r.mode == SEF_MODE_10BT); // RULE_18
  assign is_usb = (st_r.mode == SEF_MODE_USB); // RULE_18

  always_comb begin
    st_nxt = st_r;
    pin_prev = st_r.pins.filt;
    ev = 8'h00;
    clr = 8'h00;
    sticky_msk = 8'h00;
    live = 8'h00;
    lp_ok = 1'b0;
    underrun = 1'b0;

    // pins: three stages, a change counts once stages two and three agree
    st_nxt.pins.s1 = {I_RECEIVE_ENABLE_INPUT, I_FRAME, I_LINK_PULSE};
    st_nxt.pins.s2 = st_r.pins.s1;
    st_nxt.pins.s3 = st_r.pins.s2;
    for (int i = 0; i < 3; i++) begin
      if (st_r.pins.s2[i] == st_r.pins.s3[i]) begin
        st_nxt.pins.filt[i] = st_r.pins.s3[i];
      end
    end

    // link pulse width measured in cycles of the filtered pin
    case (st_r.lp_st)
      SEF_LP_IDLE: begin
        if (st_nxt.pins.filt[P_LINK] && !pin_prev[P_LINK]) begin
          st_nxt.lp_st = SEF_LP_HIGH;
          st_nxt.lp_cnt = {{(`SEF_LP_CNT_W-1){1'b0}}, 1'b1};
        end
      end
      SEF_LP_HIGH: begin
        if (!st_nxt.pins.filt[P_LINK]) begin
          st_nxt.lp_st = SEF_LP_IDLE;
          lp_ok = (st_r.lp_cnt >= LP_MIN_C) && (st_r.lp_cnt <= LP_MAX_C); // RULE_13
        end else if (st_r.lp_cnt == LP_MAX_C) begin
          // too long to be a link pulse: wait out the rest of it
          st_nxt.lp_st = SEF_LP_LONG;
        end else begin
          st_nxt.lp_cnt = st_r.lp_cnt + 1'b1;
        end
      end
      SEF_LP_LONG: begin
        if (!st_nxt.pins.filt[P_LINK]) begin
          st_nxt.lp_st = SEF_LP_IDLE;
        end
      end
      default: begin
        st_nxt.lp_st = SEF_LP_IDLE;
      end
    endcase

    // usb bit unstuffing check on the received bit stream
    if (I_EVT.rx_bit_vld) begin
      if (!I_EVT.rx_bit) begin
        st_nxt.ones = '0;
      end else if (st_r.ones == ONES_LAST) begin
        st_nxt.ones = '0;
        ev[`SEF_B_RX_ERROR] = is_usb; // RULE_04
      end else begin
        st_nxt.ones = st_r.ones + 1'b1;
      end
    end
    if (is_10bt && I_EVT.manch_err) begin
      ev[`SEF_B_RX_ERROR] = 1'b1; // RULE_03
    end

    // end of packet, source depends on protocol
    case (st_r.mode)
      SEF_MODE_10BT, SEF_MODE_USB: begin
        ev[`SEF_B_EOP] = I_EVT.rx_eop; // RULE_06
      end
      SEF_MODE_GPSI: begin
        ev[`SEF_B_EOP] = pin_prev[P_RECEIVE_ENABLE_INPUT] & ~st_nxt.pins.filt[P_RECEIVE_ENABLE_INPUT]; // RULE_07
      end
      SEF_MODE_SPI: begin
        ev[`SEF_B_EOP] = ~pin_prev[P_FRAME] & st_nxt.pins.filt[P_FRAME]; // RULE_08
      end
      default: begin
        ev[`SEF_B_EOP] = 1'b0;
      end
    endcase

    ev[`SEF_B_SYNC] = I_EVT.sync_det & (is_10bt | is_usb); // RULE_09

    // transmit buffer occupancy; a load in the same cycle as a take keeps it full
    if (I_EVT.tx_load) begin
      st_nxt.tx_loaded = 1'b1;
    end else if (I_EVT.tx_take) begin
      st_nxt.tx_loaded = 1'b0;
    end
    ev[`SEF_B_TX_EMPTY] = st_r.tx_loaded & ~st_nxt.tx_loaded; // RULE_10
    underrun = I_EVT.tx_shift_done & ~st_r.tx_loaded & ~I_EVT.tx_load; // RULE_11
    ev[`SEF_B_TX_UNDERRUN] = underrun;
    st_nxt.tx_eop_req = underrun & (is_10bt | is_usb); // RULE_12

    ev[`SEF_B_LINK_PULSE] = lp_ok & is_10bt; // RULE_13

    st_nxt.rx_full_prev = I_EVT.rx_buf_full;
    ev[`SEF_B_RX_FULL] = I_EVT.rx_buf_full & ~st_r.rx_full_prev; // RULE_15

    // live bits replace the sticky ones where the mode says so
    sticky_msk = 8'hFF;
    sticky_msk[`SEF_B_CARRIER] = 1'b0;
    if (is_usb) begin
      sticky_msk[`SEF_B_LINK_PULSE] = 1'b0;
      live[`SEF_B_LINK_PULSE] = ~I_EVT.tx_busy; // RULE_14
      live[`SEF_B_CARRIER] = ~I_EVT.rx_busy; // RULE_16
    end else if (is_10bt) begin
      live[`SEF_B_CARRIER] = 1'b0; // RULE_17
    end else begin
      live[`SEF_B_CARRIER] = I_EVT.carrier; // RULE_16
    end

    // register writes take effect at the access edge
    if (wr && hit_en) begin
      st_nxt.enable = I_APB.pwdata[7:0]; // RULE_01
    end
    if (wr && hit_md) begin
      st_nxt.mode = sef_mode_t'(I_APB.pwdata[2:0]); // RULE_18
    end
    if (wr && hit_fl) begin
      clr = ~I_APB.pwdata[7:0]; // RULE_19
    end

    // a new event wins over a clear in the same cycle
    st_nxt.flags = (((st_r.flags & ~clr) | ev) & sticky_msk) | live; // RULE_05 RULE_02

    st_nxt.irq = |(st_nxt.flags & st_nxt.enable); // RULE_01 RULE_19

    // read data is captured in the setup cycle so that it leaves a flop
    if (setup) begin
      st_nxt.prdata = 32'h0000_0000;
      if (hit_en) begin
        st_nxt.prdata[7:0] = st_r.enable;
      end
      if (hit_fl) begin
        st_nxt.prdata[7:0] = st_r.flags;
      end
      if (hit_md) begin
        st_nxt.prdata[2:0] = st_r.mode;
      end
      if (hit_st) begin
        st_nxt.prdata[`SEF_B_ST_TX_LOADED] = st_r.tx_loaded;
        st_nxt.prdata[`SEF_B_ST_LINK_PIN] = st_r.pins.filt[P_LINK];
        st_nxt.prdata[`SEF_B_ST_FRAME_PIN] = st_r.pins.filt[P_FRAME];
        st_nxt.prdata[`SEF_B_ST_RX_EN_PIN] = st_r.pins.filt[P_RECEIVE_ENABLE_INPUT];
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_r.enable <= `SEF_ENABLE_RST;
      st_r.flags <= `SEF_FLAGS_RST;
      st_r.mode <= SEF_MODE_OFF;
      st_r.pins.s1 <= `SEF_SYNC_RST;
      st_r.pins.s2 <= `SEF_SYNC_RST;
      st_r.pins.s3 <= `SEF_SYNC_RST;
      st_r.pins.filt <= `SEF_SYNC_RST;
      st_r.lp_st <= SEF_LP_IDLE;
      st_r.lp_cnt <= '0;
      st_r.ones <= '0;
      st_r.tx_loaded <= 1'b0;
      st_r.rx_full_prev <= 1'b0;
      st_r.tx_eop_req <= 1'b0;
      st_r.irq <= 1'b0;
      st_r.prdata <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  // zero wait states: every access completes in its first access cycle
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = acc & ~mapped;
  assign O_PRDATA = st_r.prdata;
  assign O_PROTOCOL_SELECT = st_r.mode;
  assign O_TX_EOP_REQ = st_r.tx_eop_req;
  assign O_IRQ = st_r.irq;

endmodule

`default_nettype wire

/* File: tb/sef_event_flags_chk.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sef_params.svh"
module sef_event_flags_chk (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // watched ports
  input wire sef_pkg::sef_apb_req_t I_APB,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire sef_pkg::sef_evt_t I_EVT,
  input wire logic [2:0] O_PROTOCOL_SELECT,
  input wire logic O_TX_EOP_REQ,
  input wire logic O_IRQ
);
  import sef_pkg::*;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  logic acc, wr, rd, map;
  assign acc = I_APB.psel && I_APB.penable;
  assign wr = acc && I_APB.pwrite;
  assign rd = acc && !I_APB.pwrite;
  assign map = I_APB.paddr inside {`SEF_OFS_ENABLE, `SEF_OFS_FLAGS, `SEF_OFS_MODE, `SEF_OFS_STATUS};
  a_ready_always: assert property (O_PREADY) else $error("pready low");
  a_err_unmapped: assert property (acc |-> O_PSLVERR == !map) else $error("pslverr wrong");
  a_read_upper_zero: assert property (rd |-> O_PRDATA[31:8] == 24'h0)
    else $error("prdata upper bits set");
  a_mode_follows: assert property (wr && I_APB.paddr == `SEF_OFS_MODE |=>
    O_PROTOCOL_SELECT == $past(I_APB.pwdata[2:0])) else $error("mode not taken");
  a_mode_read_back: assert property (rd && I_APB.paddr == `SEF_OFS_MODE |->
    O_PRDATA[2:0] == O_PROTOCOL_SELECT) else $error("mode readback wrong");
  a_irq_masked_off: assert property (wr && I_APB.paddr == `SEF_OFS_ENABLE &&
    I_APB.pwdata[7:0] == 8'h00 |=> !O_IRQ) else $error("irq with enables cleared");
  a_eop_req_single: assert property (O_TX_EOP_REQ |=> !O_TX_EOP_REQ)
    else $error("eop request longer than one cycle");
  a_eop_req_cause: assert property ($rose(O_TX_EOP_REQ) |-> $past(I_EVT.tx_shift_done) &&
    $past(O_PROTOCOL_SELECT) inside {SEF_MODE_10BT, SEF_MODE_USB})
    else $error("eop request without underrun");
  c_underrun: cover property (O_TX_EOP_REQ);
  c_irq: cover property ($rose(O_IRQ));
  c_unmapped: cover property (acc && O_PSLVERR);
endmodule
`default_nettype wire

/* File: tb/sef_dp_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sef_dp_model (
  input wire logic clk,
  output sef_pkg::sef_evt_t evt,
  output logic [2:0] pins
);
  import sef_pkg::*;
  // pins: 0 link pulse, 1 framing, 2 receive enable; all idle low
  initial begin
    evt = '0;
    pins = '0;
  end
  // one-cycle event, then a quiet cycle so pulses never merge
  task automatic pulse(input int b);
    evt[b] <= 1'b1;
    @(posedge clk);
    evt[b] <= 1'b0;
    @(posedge clk);
  endtask
  task automatic level(input int b, input logic v);
    evt[b] <= v;
    @(posedge clk);
  endtask
  task automatic pin(input int b, input int n);
    pins[b] <= 1'b1;
    repeat (n) @(posedge clk);
    pins[b] <= 1'b0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

/* File: tb/sef_event_flags_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sef_params.svh"
module sef_event_flags_tb_top;
  import sef_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sef_apb_req_t req = '0;
  logic [31:0] prdata, q;
  logic pready, pslverr, eopreq, irq, se;
  logic [2:0] mode;
  sef_evt_t evt;
  logic [2:0] pins;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  sef_dp_model dp (.clk(clk), .evt(evt), .pins(pins));
  sef_event_flags uut (.I_SYS_CLK(clk), .I_RST(rst), .I_APB(req), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_EVT(evt), .I_LINK_PULSE(pins[0]),
    .I_FRAME(pins[1]), .I_RECEIVE_ENABLE_INPUT(pins[2]), .O_PROTOCOL_SELECT(mode),
    .O_TX_EOP_REQ(eopreq), .O_IRQ(irq));
  task automatic stop_test();
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, {24'h0, e}, q);
  endtask
  // mode switch keeps old flags, so every scenario clears them after it
  task automatic setm(input logic [2:0] m);
    apb(1'b1, `SEF_OFS_MODE, {29'h0, m});
    apb(1'b1, `SEF_OFS_FLAGS, 32'h0);
  endtask
  task automatic t_reset();
    rdchk(`SEF_OFS_ENABLE, 8'h00, "enable");
    rdchk(`SEF_OFS_FLAGS, 8'h00, "flags");
    rdchk(`SEF_OFS_MODE, 8'h00, "mode");
    rdchk(12'hFF0, 8'h00, "unmapped data");
    chk("unmapped err", 32'h1, {31'h0, se});
    apb(1'b1, 12'hFF4, 32'hFFFF_FFFF);
    chk("unmapped wr err", 32'h1, {31'h0, se});
    rdchk(`SEF_OFS_ENABLE, 8'h00, "enable kept");
  endtask
  task automatic t_rxerr();
    setm(3'h1);
    dp.pulse(11);
    rdchk(`SEF_OFS_FLAGS, 8'h80, "rxerr");
    rdchk(`SEF_OFS_FLAGS, 8'h80, "sticky");
    setm(3'h2);
    dp.level(9, 1'b1);
    repeat (6) dp.pulse(10);
    rdchk(`SEF_OFS_FLAGS, 8'h05, "six ones");
    dp.pulse(10);
    rdchk(`SEF_OFS_FLAGS, 8'h85, "seven ones");
    apb(1'b1, `SEF_OFS_FLAGS, 32'h0);
    dp.level(1, 1'b1);
    dp.level(3, 1'b1);
    rdchk(`SEF_OFS_FLAGS, 8'h00, "usb busy");
    dp.level(1, 1'b0);
    dp.level(3, 1'b0);
  endtask
  task automatic t_modes();
    logic [2:0] m [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
    logic [7:0] e [6] = '{8'h01, 8'h60, 8'h65, 8'h01, 8'h41, 8'h41};
    dp.level(0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      setm(m[i]);
      dp.pulse(8);
      dp.pulse(7);
      dp.pin(1, 4);
      dp.pin(2, 4);
      repeat (6) @(posedge clk);
      rdchk(`SEF_OFS_FLAGS, e[i], "mode flags");
    end
    dp.level(0, 1'b0);
  endtask
  task automatic t_tx();
    setm(3'h1);
    apb(1'b1, `SEF_OFS_ENABLE, 32'h08);
    fork
      dp.pulse(4);
      begin
        @(posedge clk);
        @(negedge clk);
        chk("eop request", 32'h1, {31'h0, eopreq});
      end
    join
    rdchk(`SEF_OFS_FLAGS, 8'h08, "underrun");
    chk("eop one cycle", 32'h0, {31'h0, eopreq});
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, `SEF_OFS_FLAGS, 32'hFFFF_FFFF);
    rdchk(`SEF_OFS_FLAGS, 8'h08, "write one keeps");
    apb(1'b1, `SEF_OFS_FLAGS, 32'h0);
    chk("irq off", 32'h0, {31'h0, irq});
    dp.pulse(6);
    rdchk(`SEF_OFS_STATUS, 8'h01, "tx loaded");
    dp.pulse(5);
    dp.pulse(2);
    rdchk(`SEF_OFS_FLAGS, 8'h12, "empty full");
    apb(1'b1, `SEF_OFS_ENABLE, 32'h02);
    chk("irq en", 32'h1, {31'h0, irq});
    apb(1'b1, `SEF_OFS_ENABLE, 32'h00);
    chk("irq masked", 32'h0, {31'h0, irq});
  endtask
  task automatic t_link();
    setm(3'h1);
    dp.pin(0, 3);
    repeat (6) @(posedge clk);
    rdchk(`SEF_OFS_FLAGS, 8'h04, "link ok");
    apb(1'b1, `SEF_OFS_FLAGS, 32'h0);
    dp.pin(0, 8);
    repeat (6) @(posedge clk);
    rdchk(`SEF_OFS_FLAGS, 8'h00, "link long");
  endtask
  // reset in mid-run must drop mode, enable, flags and irq back to their reset values
  task automatic t_midrst();
    setm(3'h2);
    apb(1'b1, `SEF_OFS_ENABLE, 32'hFFFF_FFFF);
    chk("mode port", 32'h2, {29'h0, mode});
    chk("irq live", 32'h1, {31'h0, irq});
    rdchk(`SEF_OFS_ENABLE, 8'hFF, "enable all");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    chk("irq in reset", 32'h0, {31'h0, irq});
    rst <= 1'b0;
    @(posedge clk);
    chk("mode after reset", 32'h0, {29'h0, mode});
    rdchk(`SEF_OFS_ENABLE, 8'h00, "enable after reset");
    rdchk(`SEF_OFS_FLAGS, 8'h00, "flags after reset");
    chk("irq after reset", 32'h0, {31'h0, irq});
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_rxerr();
    t_modes();
    t_tx();
    t_link();
    t_midrst();
    stop_test();
  end
  // whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      stop_test();
    end
  end
endmodule
bind sef_event_flags sef_event_flags_chk chk (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
  .I_APB(I_APB), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .I_EVT(I_EVT), .O_PROTOCOL_SELECT(O_PROTOCOL_SELECT), .O_TX_EOP_REQ(O_TX_EOP_REQ),
  .O_IRQ(O_IRQ));
`default_nettype wire
